/* File: core/cprc_defs.svh */
`ifndef CPRC_DEFS_SVH
`define CPRC_DEFS_SVH

// System clock rate in MHz (10 ns period)
`define CPRC_CLK_MHZ          100
// Reset pulse length in microseconds (5.6 ms)
`define CPRC_POR_TIME_US      5600
// Reference oscillator nominal rate in MHz and multiplier factor
`define CPRC_REF_MHZ          6
`define CPRC_REF_MULT         8
// Reference edges that must be counted before the next edge marks the clock as running
`define CPRC_OSC_EDGES_OK     8
// Cycles without a reference edge before the clock counts as stopped
`define CPRC_OSC_TIMEOUT_CYC  64
// Width of the reset-duration counter
`define CPRC_POR_CNT_W        20
// Width of the reference watchdog counter
`define CPRC_OSC_CNT_W        7
// Reset values of the pad-facing outputs
`define CPRC_POR_OUT_RST      1'h0
`define CPRC_PWR_EN_N_RST     1'h1

`endif

/* File: core/cprc_pkg.sv */
`default_nettype none

package cprc_pkg;

  // Level inputs arriving from pins, synchronised as one bank
  typedef struct packed {
    logic supply_ok;
    logic ext_reset_n;
    logic osc;
    logic test;
    logic rom_io;
  } cprc_pins_t;

  // Requests from the serial memory engine
  typedef struct packed {
    logic sel;
    logic clk;
    logic dout;
    logic dout_en;
  } cprc_rom_req_t;

  // Drive of the three serial memory pads
  typedef struct packed {
    logic select_o;
    logic select_oe;
    logic serial_clock_o;
    logic serial_clock_oe;
    logic serial_io_o;
    logic serial_io_oe;
  } cprc_rom_pad_t;

  typedef enum logic [2:0] {
    ST_WAIT = 3'h1,
    ST_HOLD = 3'h2,
    ST_RUN  = 3'h4
  } cprc_state_t;

endpackage

`default_nettype wire

/* File: core/cprc_osc_gate.sv */
`default_nettype none

module cprc_osc_gate
  import cprc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic osc_sync,
  input  wire logic suspend,
  output var  logic osc_out
);

  // Holds low in suspend so downstream logic sees no stray half-pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      osc_out <= 1'h0;
    end else if (suspend) begin
      osc_out <= 1'h0;
    end else begin
      osc_out <= osc_sync;
    end
  end

endmodule

`default_nettype wire

/* File: core/cprc_top.sv */
// Notes on behaviour
// - In reset, rom select, clock and data pads are released, not driven.
// - After reset, the rom serial clock pad is always driven.
// - Reset output stays low 5.6 ms after supply valid and clock running.
// - External reset input low resets the device and pulls reset output low.
// - A USB bus reset never touches the reset output.
// - Power enable goes low once configured, high again during suspend.
// - Oscillator output stops toggling while the USB link is suspended.
// - A 6 MHz reference, multiplied by eight, forms the internal clock.
`include "cprc_defs.svh"
`default_nettype none

module cprc_top
  import cprc_pkg::*;
#(
  parameter int unsigned POR_CYCLES = `CPRC_POR_TIME_US * `CPRC_CLK_MHZ
)
(
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic          supply_ok,
  input  wire logic          ext_reset_n,
  input  wire logic          osc_in,
  input  wire logic          test_in,
  input  wire logic          usb_configured,
  input  wire logic          usb_suspend,
  input  wire logic          usb_bus_reset,
  input  wire cprc_rom_req_t rom_req,
  input  wire logic          rom_serial_io_i,
  output var  cprc_rom_pad_t rom_pad,
  output var  logic          rom_din,
  output var  logic          por_out_n,
  output var  logic          dev_reset_n,
  output var  logic          power_enable_n,
  output var  logic          osc_out,
  output var  logic          ref_clock_ok,
  output var  logic          test_mode
);

  localparam int unsigned REF_MULT = `CPRC_REF_MULT;
  localparam int unsigned CORE_MHZ = `CPRC_REF_MHZ * REF_MULT;
  localparam logic [`CPRC_POR_CNT_W-1:0] POR_LAST =
    `CPRC_POR_CNT_W'(POR_CYCLES - 1);
  localparam logic [`CPRC_OSC_CNT_W-1:0] OSC_TIMEOUT =
    `CPRC_OSC_CNT_W'(`CPRC_OSC_TIMEOUT_CYC);
  localparam logic [3:0] OSC_EDGES_OK = 4'(`CPRC_OSC_EDGES_OK);

  cprc_pins_t  pins_raw;
  cprc_pins_t  sync1_ff;
  cprc_pins_t  sync2_ff;
  cprc_state_t state_ff;
  cprc_state_t nxt_state;

  logic [`CPRC_POR_CNT_W-1:0] por_cnt_ff;
  logic [`CPRC_OSC_CNT_W-1:0] osc_idle_ff;
  logic [3:0]                 osc_edges_ff;
  logic                       osc_prev_ff;
  logic                       osc_ok_ff;
  logic                       osc_edge;
  logic                       restart;
  logic                       sync_suspend;

  // True in every state where the chip counts as held in reset
  function automatic logic in_reset(input cprc_state_t st);
    in_reset = (st != ST_RUN);
  endfunction

  assign pins_raw = '{supply_ok:   supply_ok,
                      ext_reset_n: ext_reset_n,
                      osc:         osc_in,
                      test:        test_in,
                      rom_io:      rom_serial_io_i};

  // Two-stage synchronisers, one per pin; the first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < $bits(cprc_pins_t); gi++) begin : g_sync
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          sync1_ff[gi] <= 1'h0;
          sync2_ff[gi] <= 1'h0;
        end else begin
          sync1_ff[gi] <= pins_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  assign osc_edge     = sync2_ff.osc & ~osc_prev_ff;
  assign sync_suspend = usb_suspend;

  // reference clock presence
  // The multiplier itself is analog; here only its 6 MHz reference is watched.
  // CORE_MHZ documents the multiplied rate and is not used for timing.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      osc_prev_ff  <= 1'h0;
      osc_idle_ff  <= '0;
      osc_edges_ff <= '0;
      osc_ok_ff    <= 1'h0;
    end else begin
      osc_prev_ff <= sync2_ff.osc;
      if (osc_edge) begin
        osc_idle_ff <= '0;
        if (osc_edges_ff != OSC_EDGES_OK) begin
          osc_edges_ff <= osc_edges_ff + 4'h1;
        end
        osc_ok_ff <= (osc_edges_ff == OSC_EDGES_OK);
      end else if (osc_idle_ff == OSC_TIMEOUT) begin
        // Suspend stops the reference too, so loss clears the ok flag only outside suspend
        osc_edges_ff <= '0;
        osc_ok_ff    <= sync_suspend & osc_ok_ff;
      end else begin
        osc_idle_ff <= osc_idle_ff + `CPRC_OSC_CNT_W'(1);
      end
    end
  end

  // usb_bus_reset deliberately not part of the restart term
  assign restart = ~sync2_ff.ext_reset_n | ~sync2_ff.supply_ok;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_WAIT: begin
        if (!restart && osc_ok_ff) begin
          nxt_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (restart) begin
          nxt_state = ST_WAIT;
        end else if (por_cnt_ff == POR_LAST) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (restart) begin
          nxt_state = ST_WAIT;
        end
      end
      default: begin
        nxt_state = ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= ST_WAIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      por_cnt_ff <= '0;
    end else if (state_ff != ST_HOLD || restart) begin
      por_cnt_ff <= '0;
    end else if (por_cnt_ff != POR_LAST) begin
      por_cnt_ff <= por_cnt_ff + `CPRC_POR_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      por_out_n   <= `CPRC_POR_OUT_RST;
      dev_reset_n <= `CPRC_POR_OUT_RST;
    end else begin
      por_out_n   <= ~in_reset(nxt_state);
      dev_reset_n <= ~in_reset(nxt_state);
    end
  end

  // power enable follows configuration and suspend
  // Bus reset drops the enable because the device is no longer configured
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_enable_n <= `CPRC_PWR_EN_N_RST;
    end else begin
      power_enable_n <= ~(usb_configured & ~usb_suspend & ~usb_bus_reset
                          & ~in_reset(state_ff));
    end
  end

  // serial clock always driven after reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rom_pad <= '0;
    end else if (in_reset(nxt_state)) begin
      rom_pad <= '0;
    end else begin
      rom_pad.select_o        <= rom_req.sel;
      rom_pad.select_oe       <= 1'h1;
      rom_pad.serial_clock_o  <= rom_req.clk;
      rom_pad.serial_clock_oe <= 1'h1;
      rom_pad.serial_io_o     <= rom_req.dout;
      rom_pad.serial_io_oe    <= rom_req.dout_en;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rom_din <= 1'h0;
    end else begin
      rom_din <= sync2_ff.rom_io;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ref_clock_ok <= 1'h0;
    end else begin
      ref_clock_ok <= osc_ok_ff;
    end
  end

  // any level other than low selects test mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      test_mode <= 1'h0;
    end else begin
      test_mode <= sync2_ff.test;
    end
  end

  cprc_osc_gate cprc_osc_gate_i (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .osc_sync (sync2_ff.osc),
    .suspend  (usb_suspend),
    .osc_out  (osc_out)
  );

endmodule

`default_nettype wire

/* File: testbench/cprc_props.sv */
`default_nettype none

module cprc_props
  import cprc_pkg::*;
#(
  parameter int unsigned POR_CYCLES = 50
)
(
  input wire logic          clk_sys,
  input wire logic          rst,
  input wire logic          supply_ok,
  input wire logic          ext_reset_n,
  input wire logic          test_in,
  input wire logic          usb_configured,
  input wire logic          usb_suspend,
  input wire logic          usb_bus_reset,
  input wire cprc_rom_pad_t rom_pad,
  input wire logic          por_out_n,
  input wire logic          power_enable_n,
  input wire logic          osc_out,
  input wire logic          ref_clock_ok,
  input wire logic          test_mode
);
  timeunit 1ns;
  timeprecision 100ps;

  // Saturates so a long hold never wraps into a false short pulse
  logic [19:0] lo_cnt_ff;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) lo_cnt_ff <= 20'h0;
    else if (por_out_n) lo_cnt_ff <= 20'h0;
    else if (lo_cnt_ff != 20'hFFFFF) lo_cnt_ff <= lo_cnt_ff + 20'h1;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_pads_released: assert property (
    !por_out_n |-> rom_pad == '0) else $error("rom pads driven in reset");
  a_clock_driven: assert property (
    por_out_n |-> rom_pad.serial_clock_oe) else $error("rom clock not driven");
  a_por_held: assert property (
    $rose(por_out_n) |-> lo_cnt_ff >= POR_CYCLES) else $error("reset pulse short");
  a_ref_first: assert property (
    $rose(por_out_n) |-> ref_clock_ok) else $error("reset ended without reference");
  a_ext_reset: assert property (
    $fell(ext_reset_n) |-> ##[0:3] !por_out_n) else $error("external reset ignored");
  a_bus_ignored: assert property (
    (ext_reset_n && supply_ok) [*4] ##0 (usb_bus_reset && por_out_n) |=> por_out_n)
    else $error("bus reset moved reset output");
  a_power_on: assert property (
    usb_configured && !usb_suspend && !usb_bus_reset && por_out_n |=> !power_enable_n)
    else $error("power enable not asserted");
  a_power_suspend: assert property (
    usb_suspend |=> power_enable_n) else $error("power enable low in suspend");
  a_osc_quiet: assert property (
    usb_suspend |=> !osc_out) else $error("oscillator output runs in suspend");
  a_test_mode: assert property (
    test_in [*5] |-> test_mode) else $error("test mode not entered");
endmodule

`default_nettype wire

/* File: testbench/cprc_board.sv */
`default_nettype none

module cprc_board
  import cprc_pkg::*;
(
  input  wire cprc_rom_pad_t rom_pad,
  input  wire logic          power_enable_n,
  output var  logic          osc_in,
  output wire logic          rom_serial_io_i,
  output wire logic          rail_on
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    osc_in = 1'h0;
    forever #83.3 osc_in = !osc_in;
  end

  assign rom_serial_io_i = rom_pad.serial_io_oe ? rom_pad.serial_io_o : 1'h1;

  // switched rail; on whenever power_enable_n is low
  assign rail_on = !power_enable_n;
endmodule

`default_nettype wire

/* File: testbench/common_pin_reset_power_control_tb.sv */
`default_nettype none

module common_pin_reset_power_control_tb;
  import cprc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned POR = 50;
  logic          clk_sys, rst, supply_ok, ext_reset_n, osc_in, test_in;
  logic          usb_configured, usb_suspend, usb_bus_reset, rom_serial_io_i;
  logic          rom_din, por_out_n, dev_reset_n, power_enable_n, osc_out;
  logic          ref_clock_ok, test_mode, rail_on;
  logic [3:0]    r;
  cprc_rom_req_t rom_req;
  cprc_rom_pad_t rom_pad;
  int            err_total, cmp_count, n;

  cprc_top #(.POR_CYCLES(POR)) cprc_top_i (.clk_sys(clk_sys), .rst(rst),
    .supply_ok(supply_ok), .ext_reset_n(ext_reset_n), .osc_in(osc_in), .test_in(test_in),
    .usb_configured(usb_configured), .usb_suspend(usb_suspend),
    .usb_bus_reset(usb_bus_reset), .rom_req(rom_req), .rom_serial_io_i(rom_serial_io_i),
    .rom_pad(rom_pad), .rom_din(rom_din), .por_out_n(por_out_n), .dev_reset_n(dev_reset_n),
    .power_enable_n(power_enable_n), .osc_out(osc_out), .ref_clock_ok(ref_clock_ok),
    .test_mode(test_mode));
  cprc_board cprc_board_i (.rom_pad(rom_pad), .power_enable_n(power_enable_n),
    .osc_in(osc_in), .rom_serial_io_i(rom_serial_io_i), .rail_on(rail_on));

  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = !clk_sys;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chkp(input cprc_rom_pad_t e);
    cmp_count++;
    if (rom_pad !== e) begin
      err_total++;
      $display("Error rom_pad expected %h seen %h", e, rom_pad);
    end
  endtask

  task automatic wait_por(output int k);
    k = 0;
    while (por_out_n !== 1'h1 && k < 3000) begin
      cyc(1);
      k++;
    end
  endtask

  // Counts changes of osc_out over 40 cycles
  task automatic osc_changes(output int k);
    logic prev;
    k = 0;
    prev = osc_out;
    repeat (40) begin
      cyc(1);
      if (osc_out !== prev) k++;
      prev = osc_out;
    end
  endtask

  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    test_done;
  end

  initial begin
    rst = 1'h1;
    supply_ok = 1'h0;
    ext_reset_n = 1'h1;
    test_in = 1'h0;
    usb_configured = 1'h0;
    usb_suspend = 1'h0;
    usb_bus_reset = 1'h0;
    rom_req = '0;
    err_total = 0;
    cmp_count = 0;
    r = 4'($urandom(76429));
    cyc(16);
    rst = 1'h0;
    cyc(4);
    chkp('0);
    chk("rom_din", 1'h1, rom_din);
    supply_ok = 1'h1;
    wait_por(n);
    chk("por_out_n", 1'h1, por_out_n);
    chk("ref_clock_ok", 1'h1, ref_clock_ok);
    chk("por_wait", 1'h1, n >= POR);
    $display("power-on done");
    for (int i = 0; i < 8; i++) begin
      rom_req = cprc_rom_req_t'($urandom());
      cyc(1);
      chkp({rom_req.sel, 1'h1, rom_req.clk, 1'h1, rom_req.dout, rom_req.dout_en});
      cyc(4);
      chk("rom_din", rom_req.dout_en ? rom_req.dout : 1'h1, rom_din);
    end
    $display("rom pads done");
    for (int i = 0; i < 24; i++) begin
      r = 4'($urandom());
      usb_configured = r[0];
      usb_suspend = r[1] & r[2];
      usb_bus_reset = r[3] & r[2] & !r[1];
      cyc(1);
      chk("power_enable_n", !(r[0] & !usb_suspend & !usb_bus_reset), power_enable_n);
      chk("por_out_n", 1'h1, por_out_n);
      chk("rail_on", r[0] & !usb_suspend & !usb_bus_reset, rail_on);
      if (usb_suspend) chk("osc_out", 1'h0, osc_out);
    end
    usb_suspend = 1'h0;
    osc_changes(n);
    chk("osc_running", 1'h1, n > 0);
    usb_suspend = 1'h1;
    cyc(1);
    osc_changes(n);
    chk("osc_stopped", 1'h1, n == 0);
    $display("power enable done");
    usb_configured = 1'h1;
    usb_suspend = 1'h0;
    usb_bus_reset = 1'h0;
    ext_reset_n = 1'h0;
    cyc(4);
    chk("por_out_n", 1'h0, por_out_n);
    chk("dev_reset_n", 1'h0, dev_reset_n);
    chk("power_enable_n", 1'h1, power_enable_n);
    chkp('0);
    ext_reset_n = 1'h1;
    cyc(POR / 2);
    ext_reset_n = 1'h0;
    cyc(3);
    ext_reset_n = 1'h1;
    wait_por(n);
    chk("por_len", 1'h1, n >= POR && n <= POR + 8);
    supply_ok = 1'h0;
    cyc(4);
    chk("por_out_n", 1'h0, por_out_n);
    supply_ok = 1'h1;
    wait_por(n);
    chk("por_len", 1'h1, n >= POR && n <= POR + 8);
    $display("external reset done");
    test_in = 1'h1;
    cyc(6);
    chk("test_mode", 1'h1, test_mode);
    test_in = 1'h0;
    cyc(6);
    chk("test_mode", 1'h0, test_mode);
    $display("test input done");
    test_done;
  end
endmodule

bind cprc_top cprc_props #(.POR_CYCLES(POR_CYCLES)) cprc_props_i (.clk_sys(clk_sys),
  .rst(rst), .supply_ok(supply_ok), .ext_reset_n(ext_reset_n), .test_in(test_in),
  .usb_configured(usb_configured), .usb_suspend(usb_suspend), .usb_bus_reset(usb_bus_reset),
  .rom_pad(rom_pad), .por_out_n(por_out_n), .power_enable_n(power_enable_n),
  .osc_out(osc_out), .ref_clock_ok(ref_clock_ok), .test_mode(test_mode));

`default_nettype wire
